// File: ipr_defs.svh
// Constants for the interrupt priority registers 4 to 6.
// Assumes inclusion by the package, the design and the bench.
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH
`define IPR_IDX_REG4 4
`define IPR_IDX_REG5 5
`define IPR_IDX_REG6 6
`define IPR_ADDR_REG4 8'h10
`define IPR_ADDR_REG5 8'h14
`define IPR_ADDR_REG6 8'h18
`define IPR_MASK_REG4 16'hFC3F
`define IPR_MASK_REG5 16'hFF3F
`define IPR_MASK_REG6 16'hFFCF
`define IPR_RESET_VAL 16'h0000
`define IPR_CODE_OFF 2'b00
`define IPR_NUM_SRC 48
`define IPR_RESP_OKAY 2'b00
`define IPR_RESP_SLVERR 2'b10
`endif

// File: ipr_pkg.sv
// Types for the interrupt priority registers 4 to 6.
// Assumes the constants header is in the include path.
`default_nettype none
`include "ipr_defs.svh"
package ipr_pkg;
  typedef logic [1:0] ipr_level_t;
  typedef struct packed {
    logic valid;
    ipr_level_t level;
  } ipr_req_s;
  typedef enum logic [1:0] {
    IPR_IDLE = 2'b00,
    IPR_RESP = 2'b01
  } ipr_state_e;
endpackage
`default_nettype wire

// File: ipr_regs.sv
// AXI4-Lite slave with priority registers 4 to 6 and request tagging.
// Assumes pending inputs come from logic on clk_sys.
// Notes on behaviour
// - Field 00 disables source; 01, 10, 11 mean levels 0, 1, 2.
// - Reset clears every priority field to the disabled code.
// - Reserved bits read zero; writes to them are ignored.
// - Register 4 bits 15-10 hold serial peripheral receive/transmit levels.
// - Register 4 bits 9-6 reserved; bits 5-0 hold port groups A, B, C.
// - Register 5 bits 15-12 hold decoder 1 index and home/watchdog levels.
// - Register 5 bits 11-8 hold serial channel 1 receive levels; 7-6 reserved.
// - Register 5 bits 5-0 hold channel 1 transmit and peripheral 0 transmit.
// - Register 6 bits 15-10 hold timer C0, D3, D2 levels.
// - Register 6 bits 9-6 hold timer D1, D0; bits 5-4 reserved.
// - Register 6 bits 3-0 hold decoder 0 index and home/watchdog levels.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ipr_defs.svh"
module ipr_regs
  import ipr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [47:0] irq_pending,
  output ipr_req_s [47:0] irq_req_r
);
  logic [15:0] irq_priority_reg_4_r;
  logic [15:0] irq_priority_reg_5_r;
  logic [15:0] irq_priority_reg_6_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_held_r;
  logic w_held_r;
  ipr_state_e wr_state_r;
  logic [47:0] field_vec;
  logic [15:0] wmerge;
  logic do_write;
  logic [15:0] rd_val;
  ipr_req_s [47:0] req_nxt;

  assign do_write = aw_held_r && w_held_r && (wr_state_r == IPR_IDLE);

  // Address and data are taken independently, in either order
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Byte-lane merge of the low halfword; upper lanes have no storage
  always_comb begin
    wmerge = 16'h0000;
    wmerge[7:0] = wdata_r[7:0];
    wmerge[15:8] = wdata_r[15:8];
  end

  function automatic logic [15:0] ipr_upd(input logic [15:0] cur, input logic [15:0] msk,
                                          input logic [15:0] d, input logic [3:0] st);
    logic [15:0] res;
    res = cur;
    if (st[0]) begin
      res[7:0] = d[7:0];
    end
    if (st[1]) begin
      res[15:8] = d[15:8];
    end
    return res & msk;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_priority_reg_4_r <= `IPR_RESET_VAL;
      irq_priority_reg_5_r <= `IPR_RESET_VAL;
      irq_priority_reg_6_r <= `IPR_RESET_VAL;
    end else if (do_write) begin
      case (awaddr_r)
        `IPR_ADDR_REG4: begin
          irq_priority_reg_4_r <= ipr_upd(irq_priority_reg_4_r, `IPR_MASK_REG4,
                                          wmerge, wstrb_r);
        end
        `IPR_ADDR_REG5: begin
          irq_priority_reg_5_r <= ipr_upd(irq_priority_reg_5_r, `IPR_MASK_REG5,
                                          wmerge, wstrb_r);
        end
        `IPR_ADDR_REG6: begin
          irq_priority_reg_6_r <= ipr_upd(irq_priority_reg_6_r, `IPR_MASK_REG6,
                                          wmerge, wstrb_r);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_state_r <= IPR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IPR_RESP_OKAY;
    end else begin
      case (wr_state_r)
        IPR_IDLE: begin
          if (do_write) begin
            wr_state_r <= IPR_RESP;
            s_axi_bvalid <= 1'b1;
            if (awaddr_r == `IPR_ADDR_REG4 || awaddr_r == `IPR_ADDR_REG5 ||
                awaddr_r == `IPR_ADDR_REG6) begin
              s_axi_bresp <= `IPR_RESP_OKAY;
            end else begin
              s_axi_bresp <= `IPR_RESP_SLVERR;
            end
          end
        end
        IPR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= IPR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_r <= IPR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    case (s_axi_araddr)
      `IPR_ADDR_REG4: rd_val = irq_priority_reg_4_r & `IPR_MASK_REG4;
      `IPR_ADDR_REG5: rd_val = irq_priority_reg_5_r & `IPR_MASK_REG5;
      `IPR_ADDR_REG6: rd_val = irq_priority_reg_6_r & `IPR_MASK_REG6;
      default: rd_val = 16'h0000;
    endcase
  end

  // Read: arready pulses once, data follows on the next edge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IPR_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_val};
        if (s_axi_araddr == `IPR_ADDR_REG4 || s_axi_araddr == `IPR_ADDR_REG5 ||
            s_axi_araddr == `IPR_ADDR_REG6) begin
          s_axi_rresp <= `IPR_RESP_OKAY;
        end else begin
          s_axi_rresp <= `IPR_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Source order: reg6 fields in [15:0], reg5 in [31:16], reg4 in [47:32] of 2-bit pairs
  assign field_vec = {irq_priority_reg_4_r, irq_priority_reg_5_r, irq_priority_reg_6_r};

  genvar gi;
  // Entries past the documented sources have no field and stay idle
  generate
    for (gi = 0; gi < `IPR_NUM_SRC; gi++) begin : g_src
      if (gi < `IPR_NUM_SRC / 2) begin : g_used
        // Code 00 blocks; otherwise level is code minus one
        assign req_nxt[gi].valid = irq_pending[gi] &&
                                   (field_vec[2*gi+1 -: 2] != `IPR_CODE_OFF);
        assign req_nxt[gi].level = field_vec[2*gi+1 -: 2] - 2'b01;
        level_cap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
          irq_req_r[gi].valid |-> irq_req_r[gi].level != 2'b11)
          else $error("request tagged above level two");
        req_follow_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
          irq_req_r[gi].valid == ($past(irq_pending[gi]) &&
                                  $past(field_vec[2*gi+1 -: 2]) != `IPR_CODE_OFF))
          else $error("request does not follow pending and enable");
      end else begin : g_idle
        assign req_nxt[gi] = '0;
        idle_entry_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
          !irq_req_r[gi].valid)
          else $error("entry without a field requested");
      end
    end
  endgenerate

  // One register stage for all request entries
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_req_r <= '0;
    end else begin
      irq_req_r <= req_nxt;
    end
  end

  // Register contents and request tagging
  disable_req_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $past(field_vec[1:0]) == `IPR_CODE_OFF |-> !irq_req_r[0].valid)
    else $error("disabled source presented a request");
  level_map_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_req_r[23].valid |-> irq_req_r[23].level == $past(field_vec[47:46]) - 2'b01)
    else $error("wrong decoded level");
  reset_clear_a: assert property (@(posedge clk_sys)
    !reset_n |=> irq_priority_reg_4_r == 16'h0000 && irq_priority_reg_5_r == 16'h0000 &&
    irq_priority_reg_6_r == 16'h0000)
    else $error("priority not cleared by reset");
  rsvd4_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_priority_reg_4_r[9:6] == 4'h0)
    else $error("reg4 reserved bits set");
  rsvd5_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_priority_reg_5_r[7:6] == 2'b00)
    else $error("reg5 reserved bits set");
  rsvd6_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_priority_reg_6_r[5:4] == 2'b00)
    else $error("reg6 reserved bits set");
  rdata_upper_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits nonzero");
  write_reg4_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write && awaddr_r == `IPR_ADDR_REG4 && wstrb_r == 4'hF |=>
    irq_priority_reg_4_r == ($past(wdata_r[15:0]) & `IPR_MASK_REG4))
    else $error("reg4 write not stored");
  write_reg5_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write && awaddr_r == `IPR_ADDR_REG5 && wstrb_r == 4'hF |=>
    irq_priority_reg_5_r == ($past(wdata_r[15:0]) & `IPR_MASK_REG5))
    else $error("reg5 write not stored");
  write_reg6_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write && awaddr_r == `IPR_ADDR_REG6 && wstrb_r == 4'hF |=>
    irq_priority_reg_6_r == ($past(wdata_r[15:0]) & `IPR_MASK_REG6))
    else $error("reg6 write not stored");
  lane_keep_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write && awaddr_r == `IPR_ADDR_REG6 && !wstrb_r[1] |=>
    irq_priority_reg_6_r[15:8] == $past(irq_priority_reg_6_r[15:8]))
    else $error("unstrobed lane of reg6 changed");
  unmapped_wr_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write && awaddr_r > `IPR_ADDR_REG6 |=> s_axi_bresp == `IPR_RESP_SLVERR &&
    $stable(irq_priority_reg_4_r) && $stable(irq_priority_reg_5_r) &&
    $stable(irq_priority_reg_6_r))
    else $error("unmapped write not refused");

  // Bus handshake timing
  bresp_time_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    do_write |=> s_axi_bvalid)
    else $error("write response late");
  aw_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_axi_awready |=> !s_axi_awready)
    else $error("awready held past one cycle");
  w_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_axi_wready |=> !s_axi_wready)
    else $error("wready held past one cycle");
  ar_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_axi_arready |=> !s_axi_arready)
    else $error("arready held past one cycle");
  rd_answer_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  // Scenarios that the bench should reach
  write_done_c: cover property (@(posedge clk_sys) s_axi_bvalid && s_axi_bready);
  read_done_c: cover property (@(posedge clk_sys) s_axi_rvalid && s_axi_rready);
  req_top_c: cover property (@(posedge clk_sys) irq_req_r[0].valid && irq_req_r[0].level == 2'b10);
  slverr_c: cover property (@(posedge clk_sys) s_axi_bvalid && s_axi_bresp == `IPR_RESP_SLVERR);
  lane_part_c: cover property (@(posedge clk_sys) do_write && wstrb_r != 4'hF);
endmodule
`default_nettype wire

// File: ipr_arb_model.sv
// Arbitration stand-in: picks the highest level among valid requests.
// Assumes request entries carry valid and a decoded level 0 to 2.
`timescale 1ns/100ps
`default_nettype none
module ipr_arb_model
  import ipr_pkg::*;
(
  input wire ipr_req_s [47:0] irq_req_r,
  output logic win_valid,
  output ipr_level_t win_level
);
  always_comb begin
    win_valid = 1'b0;
    win_level = 2'h0;
    for (int i = 0; i < 48; i++) begin
      if (irq_req_r[i].valid) begin
        if (!win_valid || irq_req_r[i].level > win_level) begin
          win_valid = 1'b1;
          win_level = irq_req_r[i].level;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: ipr_regs_tb_top.sv
// Testbench: AXI4-Lite register accesses and request checks.
// Assumes the design and the arbitration model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ipr_defs.svh"
module ipr_regs_tb_top import ipr_pkg::*; ;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] aw_addr = 8'h0, ar_addr = 8'h0;
  logic aw_vld = 0, w_vld = 0, b_rdy = 0, ar_vld = 0, r_rdy = 0;
  logic [31:0] w_data = 32'h0;
  logic [3:0] w_strb = 4'hF;
  logic [47:0] pend = 48'h0;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, win_valid;
  logic [1:0] b_resp, r_resp, r;
  logic [31:0] r_data;
  ipr_req_s [47:0] req;
  ipr_level_t win_level;
  int error_cnt = 0, checked = 0;
  logic [15:0] ev [3] = '{16'h0, 16'h0, 16'h0};
  logic [7:0] adr [3] = '{`IPR_ADDR_REG4, `IPR_ADDR_REG5, `IPR_ADDR_REG6};
  logic [15:0] msk [3] = '{16'hFC3F, 16'hFF3F, 16'hFFCF};

  always #2.5 clk_sys = ~clk_sys;

  ipr_regs i_ipr_regs (.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy), .s_axi_wdata(w_data),
    .s_axi_wstrb(w_strb), .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld), .s_axi_bready(b_rdy),
    .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld),
    .s_axi_rready(r_rdy), .irq_pending(pend), .irq_req_r(req));
  ipr_arb_model i_ipr_arb_model (.irq_req_r(req), .win_valid(win_valid),
    .win_level(win_level));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Address and data offered together; each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic aw, w;
    int n;
    aw = 0;
    w = 0;
    n = 0;
    @(posedge clk_sys);
    aw_addr <= a;
    w_data <= dat;
    aw_vld <= 1'b1;
    w_vld <= 1'b1;
    b_rdy <= 1'b1;
    while (!(aw && w && b_vld) && n < 100) begin
      @(posedge clk_sys);
      n++;
      if (aw_rdy && !aw) begin
        aw = 1;
        aw_vld <= 1'b0;
      end
      if (w_rdy && !w) begin
        w = 1;
        w_vld <= 1'b0;
      end
    end
    if (n >= 100) error_cnt++;
    r = b_resp;
    b_rdy <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar;
    int n;
    ar = 0;
    n = 0;
    @(posedge clk_sys);
    ar_addr <= a;
    ar_vld <= 1'b1;
    r_rdy <= 1'b1;
    while (!(ar && r_vld) && n < 100) begin
      @(posedge clk_sys);
      n++;
      if (ar_rdy && !ar) begin
        ar = 1;
        ar_vld <= 1'b0;
      end
    end
    if (n >= 100) error_cnt++;
    r_rdy <= 1'b0;
    cmp(r_data, exp);
    cmp(32'(r_resp), 32'(er));
  endtask

  // Requests settle one edge after the register and pending inputs
  task automatic chk_req();
    logic [1:0] c;
    logic e, mv;
    logic [1:0] ml;
    mv = 0;
    ml = 0;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 48; i++) begin
      c = (i < 24) ? ev[2 - i / 8][2 * (i % 8) +: 2] : 2'b00;
      e = pend[i] && (c != 2'b00);
      cmp(32'(req[i].valid), 32'(e));
      if (e) begin
        cmp(32'(req[i].level), 32'(c - 2'b01));
        if (!mv || c - 2'b01 > ml) ml = c - 2'b01;
        mv = 1;
      end
    end
    cmp(32'({win_valid, win_level}), 32'({mv, ml}));
  endtask

  task automatic setall(input logic [15:0] v4, input logic [15:0] v5, input logic [15:0] v6);
    logic [15:0] v [3];
    v = '{v4, v5, v6};
    for (int k = 0; k < 3; k++) begin
      wr(adr[k], {16'hFFFF, v[k]});
      cmp(32'(r), 32'(`IPR_RESP_OKAY));
      ev[k] = v[k] & msk[k];
    end
    chk_req();
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    pend <= 48'hFFFF_FFFF_FFFF;
    for (int k = 0; k < 3; k++) rdc(adr[k], 32'h0, `IPR_RESP_OKAY);
    chk_req();
    for (int k = 0; k < 3; k++) begin
      wr(adr[k], 32'hFFFF_FFFF);
      rdc(adr[k], {16'h0, msk[k]}, `IPR_RESP_OKAY);
    end
    for (int c = 0; c < 4; c++) setall({8{c[1:0]}}, {8{c[1:0]}}, {8{c[1:0]}});
    setall(16'h1B6C, 16'hE4D8, 16'h9C27);
    pend <= 48'hFFFF_FF5A_A5C3;
    setall(16'hFFFF, 16'hFFFF, 16'hFFFF);
    wr(8'h1C, 32'hFFFF_FFFF);
    cmp(32'(r), 32'(`IPR_RESP_SLVERR));
    rdc(8'h1C, 32'h0, `IPR_RESP_SLVERR);
    rdc(8'h00, 32'h0, `IPR_RESP_SLVERR);
    // Partial strobes: only the strobed byte lane of the halfword changes
    w_strb <= 4'h1;
    wr(adr[2], 32'h0000_0000);
    cmp(32'(r), 32'(`IPR_RESP_OKAY));
    w_strb <= 4'h2;
    wr(adr[1], 32'h0000_0000);
    cmp(32'(r), 32'(`IPR_RESP_OKAY));
    w_strb <= 4'hF;
    ev[2] = ev[2] & 16'hFF00;
    ev[1] = ev[1] & 16'h00FF;
    chk_req();
    for (int k = 0; k < 3; k++) rdc(adr[k], {16'h0, ev[k]}, `IPR_RESP_OKAY);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int k = 0; k < 3; k++) rdc(adr[k], 32'h0, `IPR_RESP_OKAY);
    conclude();
  end

  initial begin
    #50000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
